// ==== brake_cfg.svh ====
`ifndef BRAKE_CFG_SVH
`define BRAKE_CFG_SVH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 4
`define MS_NS 1000000
`define GRACE_MS 16'd5000
`define STANDSTILL_MS 16'd10000
`define FLASH_ON_MS 16'd250
`define FLASH_OFF_MS 16'd250
`define FLASH_GAP_MS 16'd1500
`define RED_BLINK_MS 16'd500
`define SEG_MIN_US 1250
`define REF_SEGMENTS 4
`define RPM_NS_NUM 64'd60000000000
`define BRAKE_ESCALATE 2'd3

// ****************************************
// register offsets
// ****************************************
`define OFF_CTRL 12'h000
`define OFF_MAINS_MS 12'h004
`define OFF_MIN_RPM 12'h008
`define OFF_TOL_PCT 12'h00c
`define OFF_WARN_TEMP 12'h010
`define OFF_STATUS 12'h014
`define OFF_INTERVAL 12'h018
`define OFF_REF_INTERVAL 12'h01c

// ****************************************
// fields and reset values
// ****************************************
`define CTRL_SPEED_EN 0
`define STAT_WARN 13
`define STAT_REF_VALID 14
`define STAT_MAINS_OK 15
`define MAINS_MS_RST 16'h01f4
`define MIN_RPM_RST 16'h09c4
`define TOL_PCT_RST 8'h50
`define WARN_TEMP_RST 8'h55

`endif

// ==== brake_pkg.sv ====
package brake_pkg;

    // fault sets: bit n-1 holds flash code n
    typedef struct packed {
        logic [5:0] sr;
        logic [6:0] nsr;
    } faults_s;

    // plant state from the braking controller, same clock
    typedef struct packed {
        logic ready;
        logic motor_start;
        logic bypass;
        logic braking;
        logic standstill;
        logic device_test;
        logic size_check_done;
        logic current_in_limits;
        logic start_contact_missing;
        logic safety_circuit_fault;
        logic estop;
        logic motor_overtemp;
        logic motor_cooled;
        logic thermal_full;
        logic thermal_below_80;
        logic wrong_rotation;
        logic [7:0] device_temp;
    } plant_s;

    typedef enum logic [3:0] {
        FL_IDLE = 4'b0001,
        FL_ON = 4'b0010,
        FL_OFF = 4'b0100,
        FL_GAP = 4'b1000
    } flash_e;

endpackage

// ==== brake_fault_supervisor.sv ====
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

module brake_fault_supervisor #(
    parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mains_phase_a_sense,
    input wire logic mains_phase_b_sense,
    input wire logic tool_speed_pulse_input,
    input wire brake_pkg::plant_s plant,
    output logic led_green,
    output logic led_red,
    output logic led_yellow,
    output logic start_enable,
    output logic temp_warning,
    output brake_pkg::faults_s faults
);

    // ****************************************
    // constants
    // ****************************************
    // 4-segment rpm = SPEED_K / interval; scaling to 4 segments makes
    // the min-rpm parameter mean the 4-segment value for any disc
    localparam logic [63:0] SPEED_K = `RPM_NS_NUM / 64'(`CLK_PERIOD_NS * `REF_SEGMENTS);
    // counted in clock cycles scaled by MS_CYCLES, so a shortened tick scales the segment floor too
    localparam logic [31:0] SEG_MIN_CYC = 32'((MS_CYCLES * `SEG_MIN_US) / 1000);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pin_raw;
    wire [2:0] pin_q;
    wire [2:0] pin_prev_q;
    assign pin_raw = {tool_speed_pulse_input, mains_phase_b_sense, mains_phase_a_sense};

    // three stages; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic [2:0] s_q;
            logic lvl_q;
            logic lvl_prev_q;
            assign pin_q[gi] = lvl_q;
            assign pin_prev_q[gi] = lvl_prev_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s_q <= 3'h0;
                    lvl_q <= 1'b0;
                    lvl_prev_q <= 1'b0;
                end else begin
                    s_q <= {s_q[1:0], pin_raw[gi]};
                    if (s_q[1] == s_q[2]) begin
                        lvl_q <= s_q[2];
                    end
                    lvl_prev_q <= lvl_q;
                end
            end
        end
    endgenerate

    logic mains_present;
    logic pulse_edge;
    assign mains_present = pin_q[0] | pin_q[1];
    assign pulse_edge = pin_q[2] & ~pin_prev_q[2];

    // ****************************************
    // registers over APB
    // ****************************************
    logic speed_en_q;
    logic [15:0] mains_ms_q;
    logic [15:0] min_rpm_q;
    logic [7:0] tol_pct_q;
    logic [7:0] warn_temp_q;
    logic [31:0] interval_q;
    logic [31:0] ref_interval_q;
    logic ref_valid_q;
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] rd_d;

    // one wait state: pready rises in the second access cycle
    assign access = psel & penable & ~pready;
    assign wr = psel & penable & pready & pwrite;

    // read mux and decode
    always_comb begin
        rd_d = 32'h0;
        mapped = 1'b1;
        if (paddr == `OFF_CTRL) begin
            rd_d[`CTRL_SPEED_EN] = speed_en_q;
        end else if (paddr == `OFF_MAINS_MS) begin
            rd_d[15:0] = mains_ms_q;
        end else if (paddr == `OFF_MIN_RPM) begin
            rd_d[15:0] = min_rpm_q;
        end else if (paddr == `OFF_TOL_PCT) begin
            rd_d[7:0] = tol_pct_q;
        end else if (paddr == `OFF_WARN_TEMP) begin
            rd_d[7:0] = warn_temp_q;
        end else if (paddr == `OFF_STATUS) begin
            rd_d[12:0] = faults;
            rd_d[`STAT_WARN] = temp_warning;
            rd_d[`STAT_REF_VALID] = ref_valid_q;
            rd_d[`STAT_MAINS_OK] = mains_present;
        end else if (paddr == `OFF_INTERVAL) begin
            rd_d = interval_q;
        end else if (paddr == `OFF_REF_INTERVAL) begin
            rd_d = ref_interval_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // bus answer; unmapped addresses give pslverr and zero data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            prdata <= (access & ~pwrite) ? rd_d : 32'h0;
            pslverr <= access & ~mapped;
        end
    end

    // writable settings; writes to read-only offsets are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_en_q <= 1'b0;
            mains_ms_q <= `MAINS_MS_RST;
            min_rpm_q <= `MIN_RPM_RST;
            tol_pct_q <= `TOL_PCT_RST;
            warn_temp_q <= `WARN_TEMP_RST;
        end else if (wr) begin
            if (paddr == `OFF_CTRL) begin
                speed_en_q <= pwdata[`CTRL_SPEED_EN];
            end else if (paddr == `OFF_MAINS_MS) begin
                mains_ms_q <= pwdata[15:0];
            end else if (paddr == `OFF_MIN_RPM) begin
                min_rpm_q <= pwdata[15:0];
            end else if (paddr == `OFF_TOL_PCT) begin
                tol_pct_q <= pwdata[7:0];
            end else if (paddr == `OFF_WARN_TEMP) begin
                warn_temp_q <= pwdata[7:0];
            end
        end
    end

    // ****************************************
    // millisecond tick
    // ****************************************
    logic [31:0] ms_cnt_q;
    logic ms_tick;
    assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_q <= 32'h0;
        end else begin
            ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
        end
    end

    // ****************************************
    // mains monitoring
    // ****************************************
    logic grace_q;
    logic [15:0] absent_ms_q;
    logic [15:0] mains_limit;
    logic mains_fail;
    assign mains_limit = grace_q ? `GRACE_MS : mains_ms_q;
    assign mains_fail = ~mains_present & (absent_ms_q >= mains_limit);

    // grace ends at first mains sight or once it has run out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grace_q <= 1'b1;
            absent_ms_q <= 16'h0;
        end else begin
            if (mains_present) begin
                grace_q <= 1'b0;
                absent_ms_q <= 16'h0;
            end else if (ms_tick && !mains_fail) begin
                absent_ms_q <= absent_ms_q + 16'h1;
            end
            if (mains_fail) begin
                grace_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // tool speed measurement
    // ****************************************
    logic [31:0] run_cnt_q;
    logic [31:0] eff_interval;
    logic bypass_prev_q;
    logic speed_low_min;
    logic speed_low_tol;

    // the running count covers a stalled disc that sends no edges;
    // SPEED_K fits in 32 bits, so a nonzero min-rpm trips before the count saturates
    assign eff_interval = (run_cnt_q > interval_q) ? run_cnt_q : interval_q;
    assign speed_low_min = 64'(min_rpm_q) * 64'(eff_interval) > SPEED_K;
    assign speed_low_tol = ref_valid_q &&
        (64'(tol_pct_q) * 64'(eff_interval) > 64'(ref_interval_q) * 64'd100);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt_q <= 32'h0;
            interval_q <= 32'h0;
        end else if (!speed_en_q) begin
            run_cnt_q <= 32'h0;
            interval_q <= 32'h0;
        end else if (pulse_edge) begin
            interval_q <= run_cnt_q;
            run_cnt_q <= 32'h1;
        end else if (run_cnt_q != 32'hffffffff) begin
            run_cnt_q <= run_cnt_q + 32'h1;
        end
    end

    // reference: first full interval after bypass is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bypass_prev_q <= 1'b0;
            ref_valid_q <= 1'b0;
            ref_interval_q <= 32'h0;
        end else begin
            bypass_prev_q <= plant.bypass;
            if (!plant.bypass || !speed_en_q) begin
                ref_valid_q <= 1'b0;
            end else if (pulse_edge && bypass_prev_q && !ref_valid_q && interval_q != 32'h0 &&
                         run_cnt_q >= SEG_MIN_CYC) begin
                ref_valid_q <= 1'b1;
                ref_interval_q <= run_cnt_q;
            end
        end
    end

    // ****************************************
    // braking time monitor
    // ****************************************
    logic [15:0] brake_ms_q;
    logic brake_active_q;
    logic [1:0] timeout_run_q;
    logic brake_timeout;
    assign brake_timeout = brake_active_q && !plant.standstill &&
                           ms_tick && (brake_ms_q == `STANDSTILL_MS - 16'h1);

    // consecutive count resets only on a braking that reached standstill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_ms_q <= 16'h0;
            brake_active_q <= 1'b0;
            timeout_run_q <= 2'h0;
        end else begin
            if (plant.braking && !brake_active_q && brake_ms_q == 16'h0) begin
                brake_active_q <= 1'b1;
            end else if (brake_active_q && plant.standstill) begin
                brake_active_q <= 1'b0;
                timeout_run_q <= 2'h0;
            end else if (brake_timeout) begin
                brake_active_q <= 1'b0;
                if (timeout_run_q != `BRAKE_ESCALATE) begin
                    timeout_run_q <= timeout_run_q + 2'h1;
                end
            end
            if (brake_active_q && ms_tick) begin
                brake_ms_q <= brake_ms_q + 16'h1;
            end else if (!plant.braking) begin
                brake_ms_q <= 16'h0;
            end
        end
    end

    // ****************************************
    // fault latches
    // ****************************************
    logic motor_start_prev_q;
    logic start_edge;
    logic [6:0] nsr_set;
    logic [6:0] nsr_clr;
    logic [5:0] sr_set;
    logic escalate;
    assign start_edge = plant.motor_start & ~motor_start_prev_q;
    assign escalate = brake_timeout && (timeout_run_q == `BRAKE_ESCALATE - 2'h1);

    // event sources, code n on bit n-1
    always_comb begin
        nsr_set = 7'h0;
        nsr_set[0] = mains_fail;
        nsr_set[1] = brake_timeout;
        nsr_set[2] = plant.motor_overtemp;
        nsr_set[3] = plant.thermal_full;
        nsr_set[4] = speed_en_q && plant.bypass && (speed_low_min || speed_low_tol);
        nsr_set[5] = speed_en_q && plant.standstill && pulse_edge;
        nsr_set[6] = plant.wrong_rotation;
        // temperature faults leave only on cooling, the rest on start
        nsr_clr = start_edge ? 7'h73 : 7'h0;
        nsr_clr[2] = plant.motor_cooled;
        nsr_clr[3] = plant.thermal_below_80;
        sr_set = 6'h0;
        sr_set[0] = plant.device_test && plant.size_check_done &&
                    !plant.current_in_limits;
        sr_set[1] = plant.start_contact_missing;
        sr_set[2] = escalate && !plant.device_test;
        sr_set[3] = escalate && plant.device_test;
        sr_set[4] = plant.safety_circuit_fault;
        sr_set[5] = plant.estop;
    end

    // set wins over clear; safety faults only leave on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faults <= '0;
            motor_start_prev_q <= 1'b0;
        end else begin
            motor_start_prev_q <= plant.motor_start;
            faults.nsr <= nsr_set | (faults.nsr & ~nsr_clr);
            faults.sr <= faults.sr | sr_set;
        end
    end

    // ****************************************
    // ready, start enable and warning
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_green <= 1'b0;
            start_enable <= 1'b0;
            temp_warning <= 1'b0;
        end else begin
            led_green <= plant.ready && (faults.sr == 6'h0);
            start_enable <= plant.ready && (faults.sr == 6'h0) && !sr_set[0];
            temp_warning <= plant.device_temp >= warn_temp_q;
        end
    end

    // ****************************************
    // flash code indicator
    // ****************************************
    brake_pkg::flash_e fl_q;
    logic [15:0] fl_ms_q;
    logic [2:0] fl_left_q;
    logic [15:0] red_ms_q;
    logic [2:0] code;
    logic safety_shown;

    // safety codes take precedence; lowest code of a set is shown
    always_comb begin
        code = 3'h0;
        safety_shown = faults.sr != 6'h0;
        for (int i = 6; i >= 0; i--) begin
            if (safety_shown ? (i < 6 && faults.sr[i]) : faults.nsr[i]) begin
                code = 3'(i + 1);
            end
        end
    end

    // one group: code blinks, then a long gap; a new code waits for the gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_q <= brake_pkg::FL_IDLE;
            fl_ms_q <= 16'h0;
            fl_left_q <= 3'h0;
            led_yellow <= 1'b0;
        end else begin
            if (ms_tick) begin
                fl_ms_q <= fl_ms_q + 16'h1;
            end
            case (fl_q)
                brake_pkg::FL_IDLE: begin
                    led_yellow <= 1'b0;
                    if (code != 3'h0) begin
                        fl_q <= brake_pkg::FL_ON;
                        fl_left_q <= code;
                        fl_ms_q <= 16'h0;
                        led_yellow <= 1'b1;
                    end
                end
                brake_pkg::FL_ON: begin
                    if (fl_ms_q >= `FLASH_ON_MS) begin
                        fl_q <= brake_pkg::FL_OFF;
                        fl_ms_q <= 16'h0;
                        fl_left_q <= fl_left_q - 3'h1;
                        led_yellow <= 1'b0;
                    end
                end
                brake_pkg::FL_OFF: begin
                    if (fl_left_q == 3'h0) begin
                        fl_q <= brake_pkg::FL_GAP;
                    end else if (fl_ms_q >= `FLASH_OFF_MS) begin
                        fl_q <= brake_pkg::FL_ON;
                        fl_ms_q <= 16'h0;
                        led_yellow <= 1'b1;
                    end
                end
                brake_pkg::FL_GAP: begin
                    if (fl_ms_q >= `FLASH_GAP_MS) begin
                        fl_q <= brake_pkg::FL_IDLE;
                    end
                end
                default: begin
                    fl_q <= brake_pkg::FL_IDLE;
                end
            endcase
        end
    end

    // red: steady for safety faults, blinking for the others
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_ms_q <= 16'h0;
            led_red <= 1'b0;
        end else if (faults.sr != 6'h0) begin
            led_red <= 1'b1;
        end else if (faults.nsr == 7'h0) begin
            led_red <= 1'b0;
            red_ms_q <= 16'h0;
        end else if (ms_tick) begin
            if (red_ms_q >= `RED_BLINK_MS - 16'h1) begin
                red_ms_q <= 16'h0;
                led_red <= ~led_red;
            end else begin
                red_ms_q <= red_ms_q + 16'h1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== brake_plant_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// mains and tool speed sensor stand-in
// ****************************************
module brake_plant_model (
    input wire logic pclk,
    input wire logic mains_on,
    input wire logic [15:0] seg_cycles,
    output logic phase_a,
    output logic phase_b,
    output logic pulse
);
    logic [15:0] cnt_q = 16'h0000;

    // both phases follow one switch; a single-phase loss is not modelled
    assign phase_a = mains_on;
    assign phase_b = mains_on;

    // one rising edge per segment; callers keep seg_cycles above 1.25 scaled ms
    always_ff @(posedge pclk) begin
        if (seg_cycles == 16'h0000 || cnt_q >= seg_cycles - 16'h0001) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // sensor output sits low while no disc is turning
    assign pulse = seg_cycles != 16'h0000 && cnt_q < (seg_cycles >> 1);
endmodule

`default_nettype wire

// ==== brake_fault_supervisor_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

// ****************************************
// port checker
// ****************************************
module brake_fault_supervisor_monitor #(
    parameter int MS_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire brake_pkg::plant_s plant,
    input wire logic led_green,
    input wire logic led_red,
    input wire logic start_enable,
    input wire logic temp_warning,
    input wire brake_pkg::faults_s faults
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answers after exactly one wait state, for one cycle
    chk_apb_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("apb answer not after one wait state");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");

    // safety faults stop the drive and hold red steady
    chk_green_safety: assert property ((|faults.sr) [*2] |-> !led_green && !start_enable)
        else $error("drive enabled with safety fault");
    chk_red_steady: assert property ((|faults.sr) [*2] |-> led_red)
        else $error("red not steady with safety fault");
    chk_green_ready: assert property (!plant.ready [*2] |-> !led_green)
        else $error("green lit while not ready");
    // a set safety bit may only fall through reset
    chk_sr_latch: assert property (($past(faults.sr) & ~faults.sr) == 6'h00)
        else $error("safety fault cleared without reset");
    // threshold left at its reset value by the bench
    chk_warn_temp: assert property ($stable(plant.device_temp) [*4] |->
        temp_warning == (plant.device_temp >= `WARN_TEMP_RST))
        else $error("temperature warning wrong");

    cover property ($rose(|faults.sr));
    cover property (pslverr);
    cover property ($rose(faults.nsr[4]));
endmodule

bind brake_fault_supervisor brake_fault_supervisor_monitor #(
    .MS_CYCLES(MS_CYCLES)
) i_brake_fault_supervisor_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .plant(plant),
    .led_green(led_green),
    .led_red(led_red),
    .start_enable(start_enable),
    .temp_warning(temp_warning),
    .faults(faults)
);

`default_nettype wire

// ==== brake_fault_supervisor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "brake_cfg.svh"

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, a, e); end end

module brake_fault_supervisor_tb;
    // short ms tick keeps the 5 s and 10 s counts inside the run
    localparam int MS = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, perr, led_green, led_red, led_yellow, start_enable, temp_warning;
    logic pa, pb, pulse, b;
    logic mains_on = 1'b0;
    logic [15:0] seg = 16'h0000;
    brake_pkg::plant_s plant = '0;
    brake_pkg::faults_s faults;
    int miscompares = 0;
    int tests_run = 0;
    logic [11:0] ra [5] = '{`OFF_CTRL, `OFF_MAINS_MS, `OFF_MIN_RPM, `OFF_TOL_PCT, `OFF_WARN_TEMP};
    logic [31:0] rx [5] = '{32'h0, 32'h1f4, 32'h9c4, 32'h50, 32'(`WARN_TEMP_RST)};

    always #2 pclk = ~pclk;

    brake_fault_supervisor #(.MS_CYCLES(MS)) i_brake_fault_supervisor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mains_phase_a_sense(pa), .mains_phase_b_sense(pb), .tool_speed_pulse_input(pulse),
        .plant(plant), .led_green(led_green), .led_red(led_red), .led_yellow(led_yellow),
        .start_enable(start_enable), .temp_warning(temp_warning), .faults(faults));

    brake_plant_model i_brake_plant_model (.pclk(pclk), .mains_on(mains_on),
        .seg_cycles(seg), .phase_a(pa), .phase_b(pb), .pulse(pulse));

    // ****************************************
    // tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one bus transfer; waits for pready, then releases
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // let a just-restored mains pass the synchroniser first
    task automatic start();
        cyc(6);
        plant.motor_start <= 1'b1;
        cyc(2);
        plant.motor_start <= 1'b0;
        cyc(4);
    endtask

    // align to a group start (a rise after a long low), then count one group
    task automatic flash(input int k);
        int c;
        int low;
        logic p;
        c = 1;
        low = 0;
        while (!(led_yellow === 1'b1 && low > 300 * MS)) begin
            low = (led_yellow === 1'b0) ? low + 1 : 0;
            @(posedge pclk);
        end
        p = 1'b1;
        repeat ((500 * k + 750) * MS) begin
            @(posedge pclk);
            if (led_yellow === 1'b1 && p === 1'b0) c++;
            p = led_yellow;
        end
        `CHK(c, k)
    endtask

    task automatic test_done();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog sized to about 120k cycles
    initial begin
        #480000;
        miscompares++;
        test_done();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        plant.ready = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cyc(3);
        `CHK(led_green, 1'b1)
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK(rv, rx[i])
        end
        apb(1'b0, 12'h020, 32'h0);
        `CHK(perr, 1'b1)
        $display("test registers done");
        cyc(9800);
        `CHK(faults.nsr[0], 1'b0)
        cyc(400);
        `CHK(faults.nsr[0], 1'b1)
        b = led_red;
        cyc(500 * MS);
        `CHK(led_red, ~b)
        flash(1);
        $display("test grace done");
        mains_on <= 1'b1;
        start();
        `CHK(faults.nsr[0], 1'b0)
        apb(1'b1, `OFF_MAINS_MS, 32'h0000000a);
        mains_on <= 1'b0;
        cyc(14);
        `CHK(faults.nsr[0], 1'b0)
        cyc(30);
        `CHK(faults.nsr[0], 1'b1)
        mains_on <= 1'b1;
        start();
        $display("test mains done");
        plant.motor_overtemp <= 1'b1;
        plant.thermal_full <= 1'b1;
        plant.wrong_rotation <= 1'b1;
        plant.device_temp <= `WARN_TEMP_RST;
        cyc(6);
        plant.motor_overtemp <= 1'b0;
        plant.thermal_full <= 1'b0;
        plant.wrong_rotation <= 1'b0;
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK(rv[13], 1'b1)
        `CHK(faults.nsr, 7'h4c)
        start();
        `CHK(faults.nsr, 7'h0c)
        plant.motor_cooled <= 1'b1;
        plant.device_temp <= `WARN_TEMP_RST - 8'h01;
        cyc(6);
        `CHK(faults.nsr, 7'h08)
        plant.thermal_below_80 <= 1'b1;
        cyc(6);
        `CHK(faults.nsr, 7'h00)
        $display("test thermal done");
        seg <= 16'h0064;
        cyc(500);
        apb(1'b0, `OFF_INTERVAL, 32'h0);
        `CHK(rv, 32'h0)
        apb(1'b1, `OFF_CTRL, 32'h1);
        plant.bypass <= 1'b1;
        cyc(500);
        apb(1'b0, `OFF_INTERVAL, 32'h0);
        `CHK(rv, 32'h64)
        seg <= 16'h007d;
        cyc(600);
        `CHK(faults.nsr[4], 1'b0)
        seg <= 16'h0082;
        cyc(600);
        `CHK(faults.nsr[4], 1'b1)
        plant.bypass <= 1'b0;
        plant.standstill <= 1'b1;
        cyc(300);
        `CHK(faults.nsr[5], 1'b1)
        seg <= 16'h0000;
        plant.standstill <= 1'b0;
        start();
        `CHK(faults.nsr, 7'h00)
        $display("test speed done");
        for (int i = 0; i < 3; i++) begin
            plant.braking <= 1'b1;
            cyc(9900 * MS);
            `CHK(faults.nsr[1], 1'b0)
            cyc(200 * MS);
            `CHK(faults.nsr[1], 1'b1)
            `CHK(faults.sr[2], i == 2)
            plant.braking <= 1'b0;
            start();
        end
        `CHK(faults.sr[2], 1'b1)
        flash(3);
        $display("test standstill done");
        plant.device_test <= 1'b1;
        plant.size_check_done <= 1'b1;
        plant.start_contact_missing <= 1'b1;
        plant.safety_circuit_fault <= 1'b1;
        plant.estop <= 1'b1;
        cyc(6);
        `CHK(faults.sr, 6'h37)
        `CHK(start_enable, 1'b0)
        presetn <= 1'b0;
        plant <= '{ready: 1'b1, default: '0};
        cyc(2);
        presetn <= 1'b1;
        cyc(3);
        `CHK(faults, 13'h0000)
        $display("test safety done");
        test_done();
    end
endmodule

`default_nettype wire
